// [hw/pxr_page_regs.sv]
`timescale 1ns/1ns
`default_nettype none
module pxr_page_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lite_reset,
  input wire logic eeprom_present,
  input wire logic [1:0] eeprom_wake_interval_cfg,
  input wire logic [1:0] eeprom_wake_attempt_duration_cfg,
  input wire logic otp_configured,
  input wire logic [1:0] otp_wake_interval_cfg,
  input wire logic [1:0] otp_wake_attempt_duration_cfg,
  input wire logic cfg_load,
  input wire logic rx_good_packet,
  input wire logic downshift_required,
  input wire logic link_quality_good,
  input wire logic link_up_10m,
  output logic [15:0] page_select,
  output logic fast_link_fail_en,
  output logic [1:0] crossover_mode,
  output logic [1:0] wake_interval_cfg,
  output logic [1:0] wake_attempt_duration_cfg,
  output logic rx_no_preamble_en,
  output logic cable_downshift_en,
  output logic [1:0] downshift_attempts,
  output logic main_sel,
  output logic [4:0] main_index,
  output logic main_wr,
  output logic main_rd,
  output logic [15:0] main_wdata,
  input wire logic [15:0] main_rdata,
  output logic ext2_sel
);

  // ---------------------------------------------------------------
  // input synchronisers (the four status pins arrive from outside)
  // ---------------------------------------------------------------
  localparam int NSYNC = 4;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  wire [NSYNC-1:0] sync_in = {rx_good_packet, downshift_required, link_quality_good,
                              link_up_10m};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= sync_in;
      sync_b <= sync_a;
    end
  end
  wire pkt_lvl = sync_b[3];
  wire ds_req = sync_b[2];
  wire lq_good = sync_b[1];
  wire link10 = sync_b[0];
  logic pkt_prev;
  wire pkt_evt = pkt_lvl & ~pkt_prev;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  function automatic logic is_ext(input logic [4:0] idx);
    is_ext = (idx >= pxr_pkg::IDX_EXT_FIRST) && (idx != pxr_pkg::IDX_PAGE_SEL);
  endfunction

  wire [4:0] idx = paddr[pxr_pkg::ADDR_MSB:pxr_pkg::ADDR_LSB];
  wire addr_ok = (paddr[31:pxr_pkg::ADDR_MSB+1] == '0) && (paddr[1:0] == 2'h0);
  // reads take one wait state so prdata stands at the edge that ends them
  logic rd_wait;
  wire access = psel & penable & addr_ok;
  wire wr_en = access & pwrite & (pstrb[1:0] == 2'h3);
  wire rd_en = access & ~pwrite & ~rd_wait;
  wire pg1 = (page_select == pxr_pkg::PAGE_EXT1);
  wire pg2 = (page_select == pxr_pkg::PAGE_EXT2);
  wire hit_page = (idx == pxr_pkg::IDX_PAGE_SEL);
  wire ext_idx = is_ext(idx);
  wire hit_p1 = ext_idx & pg1;
  // main page for 0..15 always, 16..30 only on page zero or reserved codes
  wire to_main = ~hit_page & (~ext_idx | (~pg1 & ~pg2));
  wire hit_cnt = hit_p1 & (idx == pxr_pkg::IDX_RX_GOOD);
  wire hit_xo = hit_p1 & (idx == pxr_pkg::IDX_XOVER);
  wire hit_c3 = hit_p1 & (idx == pxr_pkg::IDX_EXT_CTL3);

  assign pready = ~penable | pwrite | rd_wait;
  assign pslverr = 1'b0;

  // second access cycle of a read; cleared once the read completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_wait <= 1'b0;
    end else begin
      rd_wait <= psel & penable & ~pwrite & ~rd_wait;
    end
  end
  assign main_sel = psel & penable & addr_ok & to_main;
  assign main_index = idx;
  assign main_wr = wr_en & to_main;
  assign main_rd = rd_en & to_main;
  assign main_wdata = pwdata[15:0];
  // page 2 lives outside this bank; its accesses are flagged only
  assign ext2_sel = psel & penable & addr_ok & ext_idx & pg2;

  // ---------------------------------------------------------------
  // page select
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_select <= pxr_pkg::PAGE_SEL_RST;
    end else if (wr_en & hit_page) begin
      page_select <= pwdata[15:0];
    end
  end

  // ---------------------------------------------------------------
  // good packet counter, clear on read; a packet on the read edge wins
  // ---------------------------------------------------------------
  logic [pxr_pkg::CNT_W-1:0] pkt_count;
  logic pkt_active;
  wire cnt_rd = rd_en & hit_cnt;
  wire [pxr_pkg::CNT_W-1:0] cnt_base = cnt_rd ? '0 : pkt_count;
  // saturates rather than wrapping so a slow reader never sees a small count
  wire cnt_full = &pkt_count;
  logic [pxr_pkg::CNT_W-1:0] next_pkt_count;
  always_comb begin
    next_pkt_count = cnt_base;
    if (pkt_evt && !(cnt_full && !cnt_rd)) begin
      next_pkt_count = cnt_base + 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_prev <= 1'b0;
      pkt_count <= '0;
      pkt_active <= 1'b0;
    end else begin
      pkt_prev <= pkt_lvl;
      pkt_count <= next_pkt_count;
      pkt_active <= pkt_evt | (pkt_active & ~cnt_rd);
    end
  end

  // ---------------------------------------------------------------
  // crossover control
  // ---------------------------------------------------------------
  logic [1:0] xo_rsv;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_link_fail_en <= 1'b0;
      crossover_mode <= pxr_pkg::MDI_RST;
      xo_rsv <= pxr_pkg::XO_RSV_RST;
    end else if (wr_en & hit_xo) begin
      fast_link_fail_en <= pwdata[pxr_pkg::XO_FLF_BIT];
      crossover_mode <= pwdata[pxr_pkg::XO_MDI_LSB +: 2];
      // held for read-back; the host is expected to write back what it read
      xo_rsv <= pwdata[pxr_pkg::XO_RSV_LSB +: 2];
    end
  end

  // ---------------------------------------------------------------
  // extended control 3 and the image defaults of the wake timers
  // ---------------------------------------------------------------
  logic [1:0] img_interval;
  logic [1:0] img_duration;
  wire [1:0] src_interval = eeprom_present ? eeprom_wake_interval_cfg :
                            otp_configured ? otp_wake_interval_cfg :
                            pxr_pkg::INTERVAL_DFLT;
  wire [1:0] src_duration = eeprom_present ? eeprom_wake_attempt_duration_cfg :
                            otp_configured ? otp_wake_attempt_duration_cfg :
                            pxr_pkg::DURATION_DFLT;
  wire c3_wr = wr_en & hit_c3;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      img_interval <= pxr_pkg::INTERVAL_DFLT;
      img_duration <= pxr_pkg::DURATION_DFLT;
    end else if (cfg_load) begin
      img_interval <= src_interval;
      img_duration <= src_duration;
    end
  end

  // lite reset is synchronous and restores the last image, not the source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_interval_cfg <= pxr_pkg::INTERVAL_DFLT;
      wake_attempt_duration_cfg <= pxr_pkg::DURATION_DFLT;
      rx_no_preamble_en <= 1'b0;
      cable_downshift_en <= 1'b0;
      downshift_attempts <= pxr_pkg::DS_ATTEMPT_RST;
    end else if (cfg_load) begin
      wake_interval_cfg <= src_interval;
      wake_attempt_duration_cfg <= src_duration;
    end else if (lite_reset) begin
      wake_interval_cfg <= img_interval;
      wake_attempt_duration_cfg <= img_duration;
      rx_no_preamble_en <= 1'b0;
      cable_downshift_en <= 1'b0;
      downshift_attempts <= pxr_pkg::DS_ATTEMPT_RST;
    end else if (c3_wr) begin
      wake_interval_cfg <= pwdata[pxr_pkg::C3_INT_LSB +: 2];
      wake_attempt_duration_cfg <= pwdata[pxr_pkg::C3_DUR_LSB +: 2];
      rx_no_preamble_en <= pwdata[pxr_pkg::C3_NOPRE_BIT];
      cable_downshift_en <= pwdata[pxr_pkg::C3_CDS_BIT];
      downshift_attempts <= pwdata[pxr_pkg::C3_DS_LSB +: 2];
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire [15:0] rd_cnt = {pkt_active, 1'b0, pkt_count};
  wire [15:0] rd_xo = {11'h000, fast_link_fail_en, crossover_mode, xo_rsv};
  wire [15:0] rd_c3 = {1'b0, wake_interval_cfg, wake_attempt_duration_cfg, 5'h00,
                       rx_no_preamble_en, cable_downshift_en, downshift_attempts,
                       ds_req,
                       lq_good | link10};
  wire [15:0] rd_val = hit_page ? page_select :
                       to_main ? main_rdata :
                       hit_cnt ? rd_cnt :
                       hit_xo ? rd_xo :
                       hit_c3 ? rd_c3 : 16'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= {16'h0000, rd_val};
    end
  end

endmodule // pxr_page_regs
`default_nettype wire

// [pkg/pxr_pkg.sv]
package pxr_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [4:0] IDX_MAIN_LAST = 5'h0f;
  localparam logic [4:0] IDX_EXT_FIRST = 5'h10;
  localparam logic [4:0] IDX_RX_GOOD = 5'h12;
  localparam logic [4:0] IDX_XOVER = 5'h13;
  localparam logic [4:0] IDX_EXT_CTL3 = 5'h14;
  localparam logic [4:0] IDX_PAGE_SEL = 5'h1f;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 6;

  // ---------------------------------------------------------------
  // page select values
  // ---------------------------------------------------------------
  localparam logic [15:0] PAGE_MAIN = 16'h0000;
  localparam logic [15:0] PAGE_EXT1 = 16'h0001;
  localparam logic [15:0] PAGE_EXT2 = 16'h0002;
  localparam logic [15:0] PAGE_SEL_RST = 16'h0000;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CNT_ACTIVE_BIT = 15;
  localparam int CNT_W = 14;
  localparam int XO_FLF_BIT = 4;
  localparam int XO_MDI_LSB = 2;
  localparam int XO_RSV_LSB = 0;
  localparam int C3_INT_LSB = 13;
  localparam int C3_DUR_LSB = 11;
  localparam int C3_NOPRE_BIT = 5;
  localparam int C3_CDS_BIT = 4;
  localparam int C3_DS_LSB = 2;
  localparam int C3_APPLY_BIT = 1;
  localparam int C3_LQ_BIT = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] INTERVAL_DFLT = 2'h1;
  localparam logic [1:0] DURATION_DFLT = 2'h0;
  localparam logic [1:0] DS_ATTEMPT_RST = 2'h1;
  localparam logic [1:0] MDI_RST = 2'h0;
  localparam logic [1:0] XO_RSV_RST = 2'h0;

  // crossover modes
  localparam logic [1:0] MDI_AUTO = 2'h0;
  localparam logic [1:0] MDI_FORCE_MDI = 2'h2;
  localparam logic [1:0] MDI_FORCE_MDIX = 2'h3;
endpackage

// [verif/pxr_main_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ----
// main page registers behind the main port
// ----
module pxr_main_model (
  input wire logic pclk,
  input wire logic main_sel,
  input wire logic [4:0] main_index,
  input wire logic main_wr,
  input wire logic [15:0] main_wdata,
  output logic [15:0] main_rdata
);
  logic [15:0] mem [32];
  initial for (int i = 0; i < 32; i++) mem[i] = 16'h0;
  always @(posedge pclk) if (main_sel && main_wr) mem[main_index] <= main_wdata;
  // unselected: inverted data so a stale read cannot pass
  assign main_rdata = main_sel ? mem[main_index] : ~mem[main_index];
endmodule // pxr_main_model
`default_nettype wire

// [verif/pxr_page_regs_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
// ----
// routing and field checks
// ----
module pxr_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic lite_reset,
  input wire logic cfg_load,
  input wire logic [15:0] page_select,
  input wire logic fast_link_fail_en,
  input wire logic [1:0] crossover_mode,
  input wire logic [1:0] downshift_attempts,
  input wire logic main_sel,
  input wire logic ext2_sel
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc, hi, wr, p1;
  logic [4:0] ix;
  assign acc = psel & penable & (paddr[31:7] == 25'h0) & (paddr[1:0] == 2'h0);
  assign ix = paddr[6:2];
  assign hi = acc & (ix >= 5'h10) & (ix != 5'h1f);
  assign wr = acc & pwrite & (pstrb[1:0] == 2'h3);
  assign p1 = page_select == 16'h1;
  ready_now_a: assert property (psel && penable && pwrite |-> pready && !pslverr)
    else $error("access not answered");
  read_wait_a: assert property (psel && penable && !pwrite && !pready |=> pready)
    else $error("read not answered");
  page_wr_a: assert property (wr && ix == 5'h1f |=> page_select == $past(pwdata[15:0]))
    else $error("page select not written");
  low_main_a: assert property (acc && ix <= 5'h0f |-> main_sel && !ext2_sel)
    else $error("low index left main page");
  ext1_route_a: assert property (hi && p1 |-> !main_sel && !ext2_sel)
    else $error("page one access leaked");
  ext2_route_a: assert property (hi && page_select == 16'h2 |-> ext2_sel && !main_sel)
    else $error("page two access misrouted");
  main_back_a: assert property (hi && page_select == 16'h0 |-> main_sel)
    else $error("main page not restored");
  sel_top_a: assert property (acc && ix == 5'h1f |-> !main_sel && !ext2_sel)
    else $error("page select index routed away");
  xover_wr_a: assert property (wr && p1 && ix == 5'h13
    |=> {fast_link_fail_en, crossover_mode} == $past(pwdata[4:2])) else $error("crossover");
  ds_wr_a: assert property (wr && p1 && ix == 5'h14 && !cfg_load && !lite_reset
    |=> downshift_attempts == $past(pwdata[3:2])) else $error("downshift field");
  cnt_rd_a: assert property (acc && !pwrite && p1 && ix == 5'h12 |=> prdata[31:16] == 16'h0
    && !prdata[14] && (prdata[15] || prdata[13:0] == 14'h0)) else $error("counter read");
  lite_a: assert property (lite_reset && !cfg_load |=> downshift_attempts == 2'h1)
    else $error("lite reset missed");
  cover property (wr && ix == 5'h1f);
  cover property (acc && !pwrite && p1 && ix == 5'h12);
  cover property (hi && page_select == 16'h2);
endmodule // pxr_asserts
bind pxr_page_regs pxr_asserts pxr_asserts_i (.*);
`default_nettype wire

// [verif/pxr_page_regs_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
// ----
// bench
// ----
module pxr_page_regs_tb;
  logic pclk, presetn, psel, penable, pwrite, lite_reset, eeprom_present, otp_configured;
  logic cfg_load, rx_good_packet, downshift_required, link_quality_good, link_up_10m;
  logic pready, pslverr, main_sel, main_wr, main_rd, ext2_sel, fast_link_fail_en;
  logic rx_no_preamble_en, cable_downshift_en;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0] pstrb;
  logic [1:0] ee_i, ee_d, ot_i, ot_d, crossover_mode, wake_interval_cfg;
  logic [1:0] wake_attempt_duration_cfg, downshift_attempts;
  logic [4:0] main_index;
  logic [15:0] page_select, main_wdata, main_rdata, rq;
  int fails, n_checks;
  pxr_page_regs pxr_page_regs_i (.eeprom_wake_interval_cfg(ee_i),
    .eeprom_wake_attempt_duration_cfg(ee_d), .otp_wake_interval_cfg(ot_i),
    .otp_wake_attempt_duration_cfg(ot_d), .*);
  pxr_main_model pxr_main_model_i (.*);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic apb(input logic w, input logic [4:0] ix, input logic [15:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {25'h0, ix, 2'h0};
    pwdata <= {16'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fails++;
    rq = prdata[15:0];
    psel <= 1'b0;
    penable <= 1'b0;
    // let the written fields settle before anyone compares them
    @(negedge pclk);
  endtask
  task automatic rd_chk(input logic [4:0] ix, input logic [15:0] e);
    apb(1'b0, ix, 16'h0);
    `CHK("read", e, rq)
  endtask
  task automatic pulse(input logic lite);
    @(posedge pclk);
    if (lite) lite_reset <= 1'b1;
    else cfg_load <= 1'b1;
    @(posedge pclk);
    lite_reset <= 1'b0;
    cfg_load <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic t_paging();
    apb(1'b1, 5'h11, 16'h00a5);
    apb(1'b1, 5'h1f, 16'h1);
    rd_chk(5'h1f, 16'h1);
    apb(1'b1, 5'h05, 16'h5678);
    rd_chk(5'h05, 16'h5678);
    apb(1'b1, 5'h11, 16'hbeef);
    rd_chk(5'h11, 16'h0);
    apb(1'b1, 5'h1f, 16'h2);
    rd_chk(5'h1f, 16'h2);
    rd_chk(5'h12, 16'h0);
    apb(1'b1, 5'h1f, 16'h0);
    rd_chk(5'h11, 16'h00a5);
  endtask
  task automatic t_counter();
    apb(1'b1, 5'h1f, 16'h1);
    rd_chk(5'h12, 16'h0);
    repeat (3) begin
      repeat (3) @(posedge pclk);
      rx_good_packet <= 1'b1;
      repeat (3) @(posedge pclk);
      rx_good_packet <= 1'b0;
    end
    repeat (5) @(posedge pclk);
    rd_chk(5'h12, 16'h8003);
    rd_chk(5'h12, 16'h0);
  endtask
  task automatic t_xover();
    logic [1:0] m [3] = '{2'h0, 2'h2, 2'h3};
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 5'h13, 16'h0);
      // reserved low bits go back exactly as read
      apb(1'b1, 5'h13, {11'h7ff, i[0], m[i], rq[1:0]});
      `CHK("xover", {i[0], m[i]}, {fast_link_fail_en, crossover_mode})
      rd_chk(5'h13, {11'h0, i[0], m[i], 2'h0});
    end
  endtask
  task automatic t_ctl3();
    apb(1'b1, 5'h14, 16'hf7f3);
    `CHK("ctl", 8'hec, {wake_interval_cfg, wake_attempt_duration_cfg,
      rx_no_preamble_en, cable_downshift_en, downshift_attempts})
    downshift_required <= 1'b1;
    link_up_10m <= 1'b1;
    repeat (4) @(posedge pclk);
    rd_chk(5'h14, 16'h7033);
    downshift_required <= 1'b0;
    link_up_10m <= 1'b0;
    link_quality_good <= 1'b1;
    repeat (4) @(posedge pclk);
    rd_chk(5'h14, 16'h7031);
    pulse(1'b1);
    rd_chk(5'h14, 16'h2005);
    eeprom_present <= 1'b1;
    pulse(1'b0);
    apb(1'b1, 5'h14, 16'h0);
    pulse(1'b1);
    `CHK("eeprom", 4'hb, {wake_interval_cfg, wake_attempt_duration_cfg})
    eeprom_present <= 1'b0;
    pulse(1'b0);
    `CHK("otp", 4'h6, {wake_interval_cfg, wake_attempt_duration_cfg})
    otp_configured <= 1'b0;
    pulse(1'b0);
    `CHK("dflt", 4'h4, {wake_interval_cfg, wake_attempt_duration_cfg})
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, lite_reset, cfg_load, rx_good_packet} = 7'h0;
    {downshift_required, link_quality_good, link_up_10m, eeprom_present} = 4'h0;
    {paddr, pwdata} = 64'h0;
    {ee_i, ee_d, ot_i, ot_d} = 8'hb6;
    otp_configured = 1'b1;
    pstrb = 4'hf;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("reset", 23'h5, {page_select, fast_link_fail_en, crossover_mode,
      wake_interval_cfg, downshift_attempts})
    t_paging();
    t_counter();
    t_xover();
    t_ctl3();
    end_of_test();
  end
  // whole run is under two hundred cycles; over twenty times that means a hang
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    end_of_test();
  end
endmodule // pxr_page_regs_tb
`default_nettype wire
